// ===== rtc_alarm_cfg.svh
// Address map, field positions and bus constants of the alarm register block
`ifndef RTC_ALARM_CFG_SVH
`define RTC_ALARM_CFG_SVH

// ************************************************************
// Internal register addresses
// ************************************************************
`define RTC_ADDR_WK_MIN     4'h8
`define RTC_ADDR_WK_HOUR    4'h9
`define RTC_ADDR_WK_MASK    4'hA
`define RTC_ADDR_DY_MIN     4'hB
`define RTC_ADDR_DY_HOUR    4'hC

// ************************************************************
// Field positions
// ************************************************************
`define RTC_MINUTE_TENS_MSB 6
`define RTC_HOUR_TWENTY     5
`define RTC_DAY_BIT_FIRST   0
`define RTC_DAY_BIT_LAST    6

// ************************************************************
// Serial bus constants
// ************************************************************
`define RTC_SLAVE_ADDR      7'h32
`define RTC_FMT_READ_AFTER  4'h4
`define RTC_PTR_IDLE        4'hF
`define RTC_BIT_LAST        4'h7
`define RTC_BIT_ACK         4'h8
// Start leaves the clock high, so the fall that follows wraps this to zero
`define RTC_BIT_PRESTART    4'hF
`define RTC_NO_DAY          3'h7

`endif

// ===== rtc_alarm_pkg.sv
// Types shared by the alarm register block
package rtc_alarm_pkg;

  // Serial transfer phases, Gray coded along idle-addr-ptr-write
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_PTR   = 3'h3,
    ST_WRITE = 3'h2,
    ST_READ  = 3'h6,
    ST_SKIP  = 3'h7
  } bus_state_type;

endpackage

// ===== line_sampler.sv
// Two-flop synchroniser and condition detector for the two bus lines
`timescale 1ns/1ps
module line_sampler
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Raw pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  // Sampled levels and events
  output logic      scl_s,
  output logic      sda_s,
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      bus_start,
  output logic      bus_stop
);

  logic [1:0] scl_meta_r;
  logic [1:0] sda_meta_r;
  logic       scl_prev_r;
  logic       sda_prev_r;

  // ************************************************************
  // Synchronisers; idle bus level is high
  // ************************************************************
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_meta_r <= {scl_meta_r[0], scl_in};
      sda_meta_r <= {sda_meta_r[0], sda_in};
      scl_prev_r <= scl_meta_r[1];
      sda_prev_r <= sda_meta_r[1];
    end
  end

  assign scl_s     = scl_meta_r[1];
  assign sda_s     = sda_meta_r[1];
  assign scl_rise  = scl_s && !scl_prev_r;
  assign scl_fall  = !scl_s && scl_prev_r;
  // Data edges only count while the clock line stays high
  assign bus_start = scl_s && scl_prev_r && !sda_s && sda_prev_r;
  assign bus_stop  = scl_s && scl_prev_r && sda_s && !sda_prev_r;

endmodule

// ===== rtc_alarm_match_registers.sv
// Alarm register set with two-wire serial slave and alarm comparators
// ************************************************************
// Summary of operation
// - Weekly minute at 8h, bit 7 zero
// - Weekly hour at 9h, bits 7:6 zero
// - Weekly day mask at Ah, bit 7 zero
// - Hour bit 5: pm flag or twenty
// - Midnight coded 12, noon coded 32
// - Mask bits 0-6 map day codes 0-6
// - Empty day mask gives no weekly match
// - Daily minute at Bh, bit 7 zero
// - Daily hour at Ch, same coding
// - Fields undefined after halt, reserved read zero
// - Serial data output is open drain
// - Slave address 0110010 answers transfers
// - Day codes run 000 to 110
// ************************************************************
`timescale 1ns/1ps
`include "rtc_alarm_cfg.svh"
module rtc_alarm_match_registers
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // Two-wire serial bus
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Current time from the time counters, same clock
  input  wire logic [6:0] cur_minute,
  input  wire logic [5:0] cur_hour,
  input  wire logic [2:0] cur_weekday,
  // Alarm matches
  output logic            weekly_match,
  output logic            daily_match
);
  import rtc_alarm_pkg::*;

  logic [1:0]    rst_sync_r;
  logic          rst_n;
  logic          scl_s;
  logic          sda_s;
  logic          scl_rise;
  logic          scl_fall;
  logic          bus_start;
  logic          bus_stop;
  bus_state_type state_r;
  bus_state_type state_nxt;
  logic [3:0]    bit_cnt_r;
  logic [7:0]    shift_r;
  logic [7:0]    tx_r;
  logic [3:0]    ptr_r;
  logic          oe_r;
  logic          oe_nxt;
  logic [6:0]    wk_min_r;
  logic [5:0]    wk_hour_r;
  logic [6:0]    wk_mask_r;
  logic [6:0]    dy_min_r;
  logic [5:0]    dy_hour_r;
  logic          weekly_r;
  logic          daily_r;

  // ************************************************************
  // Reset release
  // ************************************************************
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  line_sampler u_sampler
  (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .bus_start (bus_start),
    .bus_stop  (bus_stop)
  );

  // ************************************************************
  // Decode
  // ************************************************************
  wire       byte_end  = scl_fall && (bit_cnt_r == `RTC_BIT_LAST);
  wire       ack_end   = scl_fall && (bit_cnt_r == `RTC_BIT_ACK);
  wire       addr_hit  = (shift_r[7:1] == `RTC_SLAVE_ADDR);
  wire       master_nak = scl_rise && (bit_cnt_r == `RTC_BIT_ACK) && sda_s;
  wire       wr_en     = byte_end && (state_r == ST_WRITE);
  wire       wr_wk_min  = wr_en && (ptr_r == `RTC_ADDR_WK_MIN);
  wire       wr_wk_hour = wr_en && (ptr_r == `RTC_ADDR_WK_HOUR);
  wire       wr_wk_mask = wr_en && (ptr_r == `RTC_ADDR_WK_MASK);
  wire       wr_dy_min  = wr_en && (ptr_r == `RTC_ADDR_DY_MIN);
  wire       wr_dy_hour = wr_en && (ptr_r == `RTC_ADDR_DY_HOUR);
  wire       acking    = (state_r == ST_ADDR && addr_hit) || (state_r == ST_PTR)
                         || (state_r == ST_WRITE);

  // Reserved bits are never stored, so they always read zero
  wire [7:0] rd_data =
    (ptr_r == `RTC_ADDR_WK_MIN)  ? {1'b0, wk_min_r}  :
    (ptr_r == `RTC_ADDR_WK_HOUR) ? {2'b00, wk_hour_r} :
    (ptr_r == `RTC_ADDR_WK_MASK) ? {1'b0, wk_mask_r} :
    (ptr_r == `RTC_ADDR_DY_MIN)  ? {1'b0, dy_min_r}  :
    (ptr_r == `RTC_ADDR_DY_HOUR) ? {2'b00, dy_hour_r} : 8'h00;

  // ************************************************************
  // Transfer phase
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    if (bus_stop)
      state_nxt = ST_IDLE;
    else if (bus_start)
      state_nxt = ST_ADDR;
    else if (byte_end)
    begin
      case (state_r)
        ST_ADDR:
          if (!addr_hit)
            state_nxt = ST_SKIP;
          else if (shift_r[0])
            state_nxt = ST_READ;
          else
            state_nxt = ST_PTR;
        ST_PTR:
          if (shift_r[3:0] == `RTC_FMT_READ_AFTER)
            state_nxt = ST_READ;
          else
            state_nxt = ST_WRITE;
        default:
          state_nxt = state_r;
      endcase
    end
    else if (master_nak && state_r == ST_READ)
      state_nxt = ST_SKIP;
  end

  // Open-drain data line: enable low for a zero, release for a one
  always_comb
  begin
    oe_nxt = oe_r;
    if (bus_start || bus_stop)
      oe_nxt = 1'b0;
    else if (byte_end)
      oe_nxt = acking;
    else if (ack_end)
      oe_nxt = (state_r == ST_READ) && !rd_data[7];
    else if (scl_fall && state_r == ST_READ && bit_cnt_r < `RTC_BIT_LAST)
      oe_nxt = !tx_r[3'h6 - bit_cnt_r[2:0]];
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      oe_r    <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      oe_r    <= oe_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      bit_cnt_r <= 4'h0;
    else if (bus_start)
      bit_cnt_r <= `RTC_BIT_PRESTART;
    else if (ack_end)
      bit_cnt_r <= 4'h0;
    else if (scl_fall)
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_r <= 8'h00;
    else if (scl_rise && bit_cnt_r < `RTC_BIT_ACK)
      shift_r <= {shift_r[6:0], sda_s};
  end

  // Pointer parks at Fh after stop; it advances once per data byte
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ptr_r <= `RTC_PTR_IDLE;
    else if (bus_stop)
      ptr_r <= `RTC_PTR_IDLE;
    else if (byte_end && state_r == ST_PTR)
      ptr_r <= shift_r[7:4];
    else if (wr_en || (ack_end && state_r == ST_READ))
      ptr_r <= ptr_r + 4'h1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_r <= 8'h00;
    else if (ack_end && state_r == ST_READ)
      tx_r <= rd_data;
  end

  // ************************************************************
  // Alarm registers
  // ************************************************************
  // Contents carry no meaning until the host writes them; zero is one such value
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wk_min_r  <= 7'h00;
      wk_hour_r <= 6'h00;
      wk_mask_r <= 7'h00;
      dy_min_r  <= 7'h00;
      dy_hour_r <= 6'h00;
    end
    else
    begin
      if (wr_wk_min)
        wk_min_r <= shift_r[`RTC_MINUTE_TENS_MSB:0];
      if (wr_wk_hour)
        wk_hour_r <= shift_r[`RTC_HOUR_TWENTY:0];
      if (wr_wk_mask)
        wk_mask_r <= shift_r[`RTC_DAY_BIT_LAST:`RTC_DAY_BIT_FIRST];
      if (wr_dy_min)
        dy_min_r <= shift_r[`RTC_MINUTE_TENS_MSB:0];
      if (wr_dy_hour)
        dy_hour_r <= shift_r[`RTC_HOUR_TWENTY:0];
    end
  end

  // ************************************************************
  // Comparators
  // ************************************************************
  // Same hour code in both modes, so plain equality covers am/pm and twenty
  wire       wk_time_eq = (cur_minute == wk_min_r) && (cur_hour == wk_hour_r);
  wire       dy_time_eq = (cur_minute == dy_min_r) && (cur_hour == dy_hour_r);
  // Code 111 is not a weekday and selects the padded zero
  wire [7:0] day_sel    = {1'b0, wk_mask_r};
  wire       day_on     = day_sel[cur_weekday];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      weekly_r <= 1'b0;
      daily_r  <= 1'b0;
    end
    else
    begin
      weekly_r <= wk_time_eq && day_on;
      daily_r  <= dy_time_eq;
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe       = oe_r;
  assign weekly_match = weekly_r;
  assign daily_match  = daily_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_weekly_match_time: assert property (
    (wk_time_eq && day_on) |=> weekly_match)
    else $error("weekly match missed");
  a_weekly_mask_empty: assert property (
    (wk_mask_r == 7'h00) |=> !weekly_match)
    else $error("weekly match with empty day mask");
  a_weekly_no_day: assert property (
    (cur_weekday == `RTC_NO_DAY) |=> !weekly_match)
    else $error("weekly match on invalid day code");
  a_day_mask_gate: assert property (
    (wk_time_eq && cur_weekday != `RTC_NO_DAY && !wk_mask_r[cur_weekday])
      |=> !weekly_match)
    else $error("weekly match on disabled day");
  a_daily_match_eq: assert property (
    daily_match |-> $past(dy_time_eq))
    else $error("daily match without time equality");
  a_minute_write: assert property (
    wr_wk_min |=> (rd_data[7] == 1'b0 || ptr_r != `RTC_ADDR_WK_MIN)
      && wk_min_r == $past(shift_r[6:0]))
    else $error("weekly minute write lost");
  a_hour_write: assert property (
    wr_wk_hour |=> wk_hour_r == $past(shift_r[5:0]))
    else $error("weekly hour write lost");
  a_mask_write: assert property (
    wr_wk_mask |=> wk_mask_r == $past(shift_r[6:0]))
    else $error("day mask write lost");
  a_daily_min_write: assert property (
    wr_dy_min |=> dy_min_r == $past(shift_r[6:0]))
    else $error("daily minute write lost");
  a_daily_hour_write: assert property (
    wr_dy_hour |=> dy_hour_r == $past(shift_r[5:0]))
    else $error("daily hour write lost");
  a_addr_ack_drive: assert property (
    (byte_end && state_r == ST_ADDR && addr_hit && !bus_start && !bus_stop)
      |=> sda_oe [*1] ##1 (sda_oe || bus_start || bus_stop))
    else $error("address not acknowledged");
  a_open_drain: assert property (
    (sda_out == 1'b0) and (bus_stop |=> !sda_oe && ptr_r == `RTC_PTR_IDLE))
    else $error("data line driven high or not released");
  a_hour_reserved: assert property (
    (ptr_r == `RTC_ADDR_WK_HOUR || ptr_r == `RTC_ADDR_DY_HOUR) |-> rd_data[7:6] == 2'b00)
    else $error("reserved hour bits not zero");

  c_weekly_fire: cover property ($rose(weekly_match));
  c_daily_fire:  cover property ($rose(daily_match));
  c_read_phase:  cover property (state_r == ST_PTR ##[1:400] state_r == ST_READ);
  c_mask_write:  cover property (wr_wk_mask);

endmodule

// ===== rtc_host_model.sv
// Host bus master model for the two-wire serial bus
`timescale 1ns/1ps
module rtc_host_model
(
  // Bus lines
  output logic       scl,
  output logic       sda_low,
  input  wire logic  sda,
  // Last results
  output logic [7:0] rx_byte,
  output logic       rx_ack
);
  event got;
  event acked;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
    rx_byte = 8'h00;
    rx_ack  = 1'b1;
  end

  // *******
  // Cycles
  // *******
  // Low for 100 ns so a late slave answer settles before the rise
  // Steps are whole clock periods, so edges keep the caller's offset
  task automatic bit_io(input logic b, output logic r);
    #40 sda_low = ~b;
    #60 scl = 1'b1;
    #60 r = sda;
    scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic ao,
                      output logic [7:0] rx, output logic ai);
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ao, ai);
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] r;
    xfer(b, 1'b1, r, rx_ack);
    -> acked;
  endtask

  task automatic get(input logic nak);
    logic a;
    xfer(8'hFF, nak, rx_byte, a);
    -> got;
  endtask

  // Also serves as repeated start from mid frame
  task automatic start();
    #40 sda_low = 1'b0;
    #60 scl = 1'b1;
    #60 sda_low = 1'b1;
    #60 scl = 1'b0;
  endtask

  // Clock rests high after the frame
  task automatic stop();
    #40 sda_low = 1'b1;
    #60 scl = 1'b1;
    #60 sda_low = 1'b0;
    #60;
  endtask
endmodule

// ===== tb_rtc_alarm_match_registers.sv
// Self-checking bench of the alarm register block
`timescale 1ns/1ps
module tb_rtc_alarm_match_registers;
  localparam logic [6:0] DEV = 7'h32;
  localparam logic [7:0] MSK [5] = '{8'h7F, 8'h3F, 8'h7F, 8'h7F, 8'h3F};
  // Real times only: 12 h codes, then 24 h codes
  localparam logic [7:0] MNS [6] = '{8'h00, 8'h30, 8'h59, 8'h00, 8'h30, 8'h59};
  localparam logic [7:0] HRS [12] = '{8'h12, 8'h01, 8'h11, 8'h32, 8'h21, 8'h31,
    8'h00, 8'h01, 8'h11, 8'h12, 8'h13, 8'h23};

  logic       core_clk;
  logic       rstn;
  logic       scl;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe;
  logic [6:0] cur_minute;
  logic [5:0] cur_hour;
  logic [2:0] cur_weekday;
  logic       weekly_match;
  logic       daily_match;
  logic [7:0] rx_byte;
  logic       rx_ack;
  logic [7:0] byte_q[$];
  logic [1:0] flag_q[$];
  logic [7:0] wd[$];
  logic [7:0] ed[$];
  logic [7:0] b;
  int         err_total;
  int         cmp_count;
  event       mt_evt;
  wire        sda;

  // Pull-up on the data line
  assign sda = ~sda_low & ~(sda_oe & ~sda_out);

  rtc_alarm_match_registers dut_u
  (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .scl_in       (scl),
    .sda_in       (sda),
    .sda_out      (sda_out),
    .sda_oe       (sda_oe),
    .cur_minute   (cur_minute),
    .cur_hour     (cur_hour),
    .cur_weekday  (cur_weekday),
    .weekly_match (weekly_match),
    .daily_match  (daily_match)
  );

  rtc_host_model host_u
  (
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda),
    .rx_byte (rx_byte),
    .rx_ack  (rx_ack)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // *******
  // Checks
  // *******
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk_flag(input logic [1:0] e, input logic [1:0] g);
    chk_byte({6'h00, e}, {6'h00, g});
  endtask

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic done_t(input string s);
    $display("test %s done", s);
  endtask

  // *******
  // Drivers
  // *******
  task automatic snd(input logic [7:0] v, input logic ea);
    flag_q.push_back({1'b0, ea});
    host_u.send(v);
  endtask

  task automatic wr_regs(input logic [3:0] p, input logic [7:0] d[$]);
    host_u.start();
    snd({DEV, 1'b0}, 1'b0);
    snd({p, 4'h0}, 1'b0);
    foreach (d[i])
      snd(d[i], 1'b0);
    host_u.stop();
  endtask

  // Pointer then direct read, or repeated start read
  task automatic rd_regs(input logic [3:0] p, input logic [7:0] e[$], input logic rs);
    host_u.start();
    snd({DEV, 1'b0}, 1'b0);
    snd({p, rs ? 4'h0 : 4'h4}, 1'b0);
    if (rs)
    begin
      host_u.start();
      snd({DEV, 1'b1}, 1'b0);
    end
    foreach (e[i])
    begin
      byte_q.push_back(e[i]);
      host_u.get(i == e.size() - 1);
    end
    host_u.stop();
  endtask

  task automatic set_time(input logic [6:0] m, input logic [5:0] h,
                          input logic [2:0] d, input logic [1:0] e);
    @(posedge core_clk);
    #1;
    cur_minute  = m;
    cur_hour    = h;
    cur_weekday = d;
    flag_q.push_back(e);
    repeat (2) @(posedge core_clk);
    #1;
    -> mt_evt;
  endtask

  initial
  forever
  begin
    @(host_u.got);
    chk_byte(byte_q.pop_front(), rx_byte);
  end

  initial
  forever
  begin
    @(host_u.acked);
    chk_flag(flag_q.pop_front(), {1'b0, rx_ack});
  end

  initial
  forever
  begin
    @(mt_evt);
    chk_flag(flag_q.pop_front(), {weekly_match, daily_match});
  end

  // About four times the expected run
  initial
  begin
    #1_000_000;
    err_total++;
    close_out();
  end

  initial
  begin
    rstn        = 1'b0;
    cur_minute  = 7'h7F;
    cur_hour    = 6'h3F;
    cur_weekday = 3'h7;
    err_total   = 0;
    cmp_count   = 0;
    repeat (12) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (5) @(posedge core_clk);
    #1;
    void'($urandom(32'h0595DD75));
    rd_regs(4'h8, {8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0);
    done_t("reset values");
    for (int k = 0; k < 5; k++)
    begin
      wd = {};
      ed = {};
      for (int i = 0; i < 5; i++)
      begin
        b = (k == 0) ? 8'hFF : 8'($urandom);
        wd.push_back(b);
        ed.push_back(b & MSK[i]);
      end
      wr_regs(4'h8, wd);
      rd_regs(4'h8, ed, k[0]);
    end
    wr_regs(4'hD, {8'h55});
    rd_regs(4'hD, {8'h00}, 1'b1);
    host_u.start();
    snd({DEV ^ 7'h01, 1'b0}, 1'b1);
    host_u.stop();
    // Read with no pointer byte starts at the parked pointer
    host_u.start();
    snd({DEV, 1'b1}, 1'b0);
    byte_q.push_back(8'h00);
    host_u.get(1'b1);
    host_u.stop();
    done_t("register map");
    wr_regs(4'h8, {8'h00, 8'h12, 8'h00, 8'h30, 8'h32});
    for (int d = 0; d < 7; d++)
      set_time(7'h00, 6'h12, 3'(d), 2'b00);
    for (int d = 0; d < 7; d++)
    begin
      wr_regs(4'hA, {8'(1 << d)});
      set_time(7'h00, 6'h12, 3'(d), 2'b10);
      set_time(7'h00, 6'h12, 3'((d + 1) % 7), 2'b00);
      set_time(7'h01, 6'h12, 3'(d), 2'b00);
    end
    wr_regs(4'hA, {8'h7F});
    set_time(7'h00, 6'h12, 3'h7, 2'b00);
    wr_regs(4'hA, {8'h00});
    done_t("weekly alarm");
    for (int i = 0; i < 12; i++)
    begin
      wr_regs(4'hB, {MNS[i % 6], HRS[i]});
      set_time(MNS[i % 6][6:0], HRS[i][5:0], 3'(i % 7), 2'b01);
      set_time(MNS[i % 6][6:0], HRS[i][5:0] ^ 6'h20, 3'h0, 2'b00);
    end
    done_t("daily alarm");
    close_out();
  end
endmodule
